// >>> hw/rhpm_pkg.sv
// constants and carriers of the root hub port mask register block
// assumes one 50 MHz clock shared by the command port and power logic
package rhpm_pkg;

   localparam int unsigned RHPM_DATA_W  = 32;
   localparam int unsigned RHPM_CODE_W  = 8;
   localparam int unsigned RHPM_FIELD_W = 3;

   // command codes of the one register
   localparam logic [7:0] RHPM_CODE_READ  = 8'h13;
   localparam logic [7:0] RHPM_CODE_WRITE = 8'h93;

   // field positions inside the 32-bit word
   localparam int unsigned RHPM_MASK_LSB = 16;
   localparam int unsigned RHPM_MASK_MSB = 18;
   localparam int unsigned RHPM_REM_LSB  = 0;
   localparam int unsigned RHPM_REM_MSB  = 2;

   // port numbering and the reserved field bit 0
   localparam int unsigned RHPM_PORT_FIRST = 1;
   localparam int unsigned RHPM_PORT_LAST  = 2;
   localparam logic [2:0]  RHPM_FIELD_USED = 3'h6;

   // reset values
   localparam logic [2:0]  RHPM_MASK_RST  = 3'h0;
   localparam logic [2:0]  RHPM_REM_RST   = 3'h0;
   localparam logic        RHPM_POWER_RST = 1'h0;

   // power switch select encoding
   localparam logic        RHPM_PSEL_GLOBAL  = 1'h0;
   localparam logic        RHPM_PSEL_PERPORT = 1'h1;

   typedef struct packed {
      logic                   valid;
      logic [RHPM_CODE_W-1:0] code;
      logic [RHPM_DATA_W-1:0] wrData;
   } rhpm_cmd_s;

   typedef struct packed {
      logic [RHPM_FIELD_W-1:0] setPorts;
      logic [RHPM_FIELD_W-1:0] clrPorts;
   } rhpm_port_cmd_s;

endpackage

// >>> hw/rhpm_port_mask_reg.sv
// root hub port descriptor register with per-port power gating
// assumes the command port and power commands share one clock domain
`timescale 1ns/1ps
module rhpm_port_mask_reg (
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire rhpm_pkg::rhpm_cmd_s       cmdReq,
   output logic [31:0]                    rdData,
   output logic                           rdValid,
   input  wire logic                      powerSwitchSelect,
   input  wire logic                      allPortsPowerOn,
   input  wire logic                      allPortsPowerOff,
   input  wire rhpm_pkg::rhpm_port_cmd_s  singlePortPowerCmd,
   output logic [2:0]                     portPowerMask,
   output logic [2:0]                     removableDeviceFlags,
   output logic [2:0]                     portPowerState
);

   localparam int unsigned DW = rhpm_pkg::RHPM_DATA_W;
   localparam int unsigned FW = rhpm_pkg::RHPM_FIELD_W;

   logic [FW-1:0] mask_r;
   logic [FW-1:0] mask_nxt;
   logic [FW-1:0] removable_r;
   logic [FW-1:0] removable_nxt;
   logic [DW-1:0] rdData_r;
   logic [DW-1:0] rdData_nxt;
   logic          rdValid_r;

   logic          readHit;
   logic          writeHit;
   logic [FW-1:0] wrMaskField;
   logic [FW-1:0] wrRemField;
   logic [DW-1:0] regWord;
   logic          perPortMode;

   // command decode, anything else is silently dropped
   assign readHit  = cmdReq.valid
                   && (cmdReq.code == rhpm_pkg::RHPM_CODE_READ);
   assign writeHit = cmdReq.valid
                   && (cmdReq.code == rhpm_pkg::RHPM_CODE_WRITE);

   // field extraction, reserved bit 0 of each field never stored
   assign wrMaskField = cmdReq.wrData[rhpm_pkg::RHPM_MASK_MSB:
                                      rhpm_pkg::RHPM_MASK_LSB]
                      & rhpm_pkg::RHPM_FIELD_USED;
   assign wrRemField  = cmdReq.wrData[rhpm_pkg::RHPM_REM_MSB:
                                      rhpm_pkg::RHPM_REM_LSB]
                      & rhpm_pkg::RHPM_FIELD_USED;

   assign mask_nxt      = writeHit ? wrMaskField : mask_r;
   assign removable_nxt = writeHit ? wrRemField  : removable_r;

   // read word: unused bits are zero by construction
   assign regWord = (DW'(mask_r) << rhpm_pkg::RHPM_MASK_LSB)
                  | (DW'(removable_r) << rhpm_pkg::RHPM_REM_LSB);
   assign rdData_nxt = readHit ? regWord : rdData_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mask_r      <= rhpm_pkg::RHPM_MASK_RST;
         removable_r <= rhpm_pkg::RHPM_REM_RST;
      end else begin
         mask_r      <= mask_nxt;
         removable_r <= removable_nxt;
      end
   end

   // read data held until the next read so slow readers can sample
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdData_r  <= '0;
         rdValid_r <= 1'h0;
      end else begin
         rdData_r  <= rdData_nxt;
         rdValid_r <= readHit;
      end
   end

   assign rdData               = rdData_r;
   assign rdValid              = rdValid_r;
   assign portPowerMask        = mask_r;
   // flags passed as stored: 0 removable, 1 fixed
   assign removableDeviceFlags = removable_r;

   // global select makes the mask invisible to the ports
   assign perPortMode = (powerSwitchSelect
                         == rhpm_pkg::RHPM_PSEL_PERPORT);

   // reserved port 0 has no switch
   assign portPowerState[0] = 1'h0;

   for (genvar p = rhpm_pkg::RHPM_PORT_FIRST;
        p <= rhpm_pkg::RHPM_PORT_LAST; p++) begin : g_port
      rhpm_port_power u_power (
         .clock            (clock),
         .rst_n            (rst_n),
         .perPortMode      (perPortMode),
         .maskBit          (mask_r[p]),
         .allPortsPowerOn  (allPortsPowerOn),
         .allPortsPowerOff (allPortsPowerOff),
         .portSet          (singlePortPowerCmd.setPorts[p]),
         .portClr          (singlePortPowerCmd.clrPorts[p]),
         .portPowerState   (portPowerState[p])
      );
   end

   // checks watch the ports, not the decode wires, where they can

   sequence s_write_cmd;
      cmdReq.valid && (cmdReq.code == rhpm_pkg::RHPM_CODE_WRITE);
   endsequence

   sequence s_read_cmd;
      cmdReq.valid && (cmdReq.code == rhpm_pkg::RHPM_CODE_READ);
   endsequence

   chk_write_then_read: assert property (
      @(posedge clock) disable iff (!rst_n)
      (s_write_cmd ##1 s_read_cmd)
      |=> rdValid && (rdData[18:16] == ($past(cmdReq.wrData[18:16], 2)
                                        & 3'h6)))
      else $error("written mask not returned by read");

   chk_mask_field_store: assert property (
      @(posedge clock) disable iff (!rst_n)
      s_write_cmd |=> portPowerMask == ($past(cmdReq.wrData[18:16])
                                        & 3'h6))
      else $error("mask field not stored from bits 18 to 16");

   chk_rem_field_store: assert property (
      @(posedge clock) disable iff (!rst_n)
      s_write_cmd |=> removableDeviceFlags
                      == ($past(cmdReq.wrData[2:0]) & 3'h6))
      else $error("removable field not stored from bits 2 to 0");

   chk_reserved_read_zero: assert property (
      @(posedge clock) disable iff (!rst_n)
      rdValid |-> (rdData[31:19] == 13'h0) && (rdData[15:3] == 13'h0)
                  && !rdData[16] && !rdData[0])
      else $error("reserved bits read nonzero");

   chk_read_pulse_once: assert property (
      @(posedge clock) disable iff (!rst_n)
      s_read_cmd |=> rdValid ##1 (rdValid == $past(cmdReq.valid
                     && (cmdReq.code == rhpm_pkg::RHPM_CODE_READ))))
      else $error("read answer timing wrong");

   chk_other_code_ignored: assert property (
      @(posedge clock) disable iff (!rst_n)
      (cmdReq.valid && (cmdReq.code != rhpm_pkg::RHPM_CODE_READ)
       && (cmdReq.code != rhpm_pkg::RHPM_CODE_WRITE))
      |=> $stable(portPowerMask) && !rdValid
          && $stable(removableDeviceFlags))
      else $error("unknown code had an effect");

   chk_perport_cmd_global: assert property (
      @(posedge clock) disable iff (!rst_n)
      (!perPortMode && !allPortsPowerOn && !allPortsPowerOff)
      |=> $stable(portPowerState))
      else $error("per-port command acted in global mode");

   chk_masked_port_set: assert property (
      @(posedge clock) disable iff (!rst_n)
      (perPortMode && mask_r[2] && singlePortPowerCmd.setPorts[2]
       && !singlePortPowerCmd.clrPorts[2])
      |=> portPowerState[2])
      else $error("masked port ignored per-port set");

   chk_unmasked_global_off: assert property (
      @(posedge clock) disable iff (!rst_n)
      (perPortMode && !mask_r[1] && allPortsPowerOff)
      |=> !portPowerState[1])
      else $error("unmasked port missed global power off");

   chk_unmasked_perport: assert property (
      @(posedge clock) disable iff (!rst_n)
      (perPortMode && !mask_r[1] && !allPortsPowerOn
       && !allPortsPowerOff)
      |=> $stable(portPowerState[1]))
      else $error("unmasked port moved without a global command");

   chk_global_on_all: assert property (
      @(posedge clock) disable iff (!rst_n)
      (!powerSwitchSelect && allPortsPowerOn && !allPortsPowerOff)
      |=> (portPowerState[2:1] == 2'h3))
      else $error("global mode power on missed a port");

   // masked port must ride through a global off untouched
   chk_masked_global_off: assert property (
      @(posedge clock) disable iff (!rst_n)
      (powerSwitchSelect && mask_r[2] && allPortsPowerOff
       && !singlePortPowerCmd.setPorts[2]
       && !singlePortPowerCmd.clrPorts[2])
      |=> $stable(portPowerState[2]))
      else $error("masked port obeyed global power off");

   chk_reserved_bits_zero: assert property (
      @(posedge clock) disable iff (!rst_n)
      !portPowerMask[0] && !removableDeviceFlags[0] && !portPowerState[0])
      else $error("reserved port bit set");

   chk_flags_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      !(cmdReq.valid && (cmdReq.code == rhpm_pkg::RHPM_CODE_WRITE))
      |=> $stable(removableDeviceFlags) && $stable(portPowerMask))
      else $error("stored field changed without a write");

   chk_read_data_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      !(cmdReq.valid && (cmdReq.code == rhpm_pkg::RHPM_CODE_READ))
      |=> $stable(rdData))
      else $error("read data moved without a read");

endmodule // rhpm_port_mask_reg

// >>> hw/rhpm_port_power.sv
// one downstream port's power state flip-flop
// assumes command pulses come from logic on the same clock
`timescale 1ns/1ps
module rhpm_port_power (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic perPortMode,
   input  wire logic maskBit,
   input  wire logic allPortsPowerOn,
   input  wire logic allPortsPowerOff,
   input  wire logic portSet,
   input  wire logic portClr,
   output logic      portPowerState
);

   logic powerState_r;
   logic powerState_nxt;
   logic maskActive;
   logic globalOwns;
   logic turnOn;
   logic turnOff;

   // mask means nothing in global mode
   assign maskActive = perPortMode && maskBit;
   assign globalOwns = !maskActive;
   // off wins when both arrive together: safer for the supply
   assign turnOff = (globalOwns && allPortsPowerOff)
                  || (maskActive && portClr);
   assign turnOn  = (globalOwns && allPortsPowerOn)
                  || (maskActive && portSet);
   assign powerState_nxt = turnOff ? 1'h0 :
                           turnOn  ? 1'h1 : powerState_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         powerState_r <= rhpm_pkg::RHPM_POWER_RST;
      end else begin
         powerState_r <= powerState_nxt;
      end
   end

   assign portPowerState = powerState_r;

   chk_masked_global_ignored: assert property (
      @(posedge clock) disable iff (!rst_n)
      (perPortMode && maskBit && !portSet && !portClr)
      |=> $stable(portPowerState))
      else $error("masked port moved on a global command");

   chk_unmasked_global_on: assert property (
      @(posedge clock) disable iff (!rst_n)
      (perPortMode && !maskBit && allPortsPowerOn && !allPortsPowerOff)
      |=> portPowerState)
      else $error("unmasked port missed global power on");

   chk_global_mode_off: assert property (
      @(posedge clock) disable iff (!rst_n)
      (!perPortMode && allPortsPowerOff) |=> !portPowerState)
      else $error("global mode power off ignored");

endmodule // rhpm_port_power

// >>> verif/rhpm_port_mask_reg_tb_top.sv
// self-checking bench of the root hub port mask register block
// assumes the bench alone drives every input; one 50 MHz clock
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errCount++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module rhpm_port_mask_reg_tb_top;
   logic                     clock;
   logic                     rst_n;
   rhpm_pkg::rhpm_cmd_s      cmdReq;
   logic [31:0]              rdData;
   logic                     rdValid;
   logic                     powerSwitchSelect;
   logic                     allPortsPowerOn;
   logic                     allPortsPowerOff;
   rhpm_pkg::rhpm_port_cmd_s singlePortPowerCmd;
   logic [2:0]               portPowerMask;
   logic [2:0]               removableDeviceFlags;
   logic [2:0]               portPowerState;
   int                       errCount;
   int                       compares;

   rhpm_port_mask_reg uut (
      .clock                (clock),
      .rst_n                (rst_n),
      .cmdReq               (cmdReq),
      .rdData               (rdData),
      .rdValid              (rdValid),
      .powerSwitchSelect    (powerSwitchSelect),
      .allPortsPowerOn      (allPortsPowerOn),
      .allPortsPowerOff     (allPortsPowerOff),
      .singlePortPowerCmd   (singlePortPowerCmd),
      .portPowerMask        (portPowerMask),
      .removableDeviceFlags (removableDeviceFlags),
      .portPowerState       (portPowerState)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, errCount);
      if (errCount == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one-cycle command; outputs settle on the edge that takes it
   task automatic sendCmd(input logic [7:0] code, input logic [31:0] data);
      @(posedge clock);
      cmdReq <= '{valid: 1'b1, code: code, wrData: data};
      @(posedge clock);
      cmdReq.valid <= 1'b0;
      #1;
   endtask

   task automatic readCheck(input logic [31:0] exp);
      sendCmd(rhpm_pkg::RHPM_CODE_READ, 32'h0000_0000);
      `CHK(rdValid, 1'b1)
      `CHK(rdData, exp)
      @(posedge clock);
      #1;
      `CHK(rdValid, 1'b0)
   endtask

   // one-cycle power pulse set; off wins only if both given
   task automatic pulse(input logic on, input logic off,
                        input logic [2:0] setP, input logic [2:0] clrP);
      @(posedge clock);
      allPortsPowerOn    <= on;
      allPortsPowerOff   <= off;
      singlePortPowerCmd <= '{setPorts: setP, clrPorts: clrP};
      @(posedge clock);
      allPortsPowerOn    <= 1'b0;
      allPortsPowerOff   <= 1'b0;
      singlePortPowerCmd <= '{setPorts: 3'h0, clrPorts: 3'h0};
      #1;
   endtask

   initial begin
      #100000;
      errCount++;
      conclude();
   end

   initial begin
      rst_n              = 1'b0;
      cmdReq             = '{valid: 1'b0, code: 8'h00, wrData: 32'h0};
      powerSwitchSelect  = 1'b0;
      allPortsPowerOn    = 1'b0;
      allPortsPowerOff   = 1'b0;
      singlePortPowerCmd = '{setPorts: 3'h0, clrPorts: 3'h0};
      errCount           = 0;
      compares           = 0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      `CHK(portPowerMask, 3'h0)
      `CHK(removableDeviceFlags, 3'h0)
      `CHK(portPowerState, 3'h0)
      `CHK(rdValid, 1'b0)
      // all ones: reserved bits must vanish
      sendCmd(rhpm_pkg::RHPM_CODE_WRITE, 32'hFFFF_FFFF);
      `CHK(portPowerMask, 3'h6)
      `CHK(removableDeviceFlags, 3'h6)
      readCheck(32'h0006_0006);
      // neighbour codes are not this register
      sendCmd(8'h94, 32'h0000_0000);
      `CHK(portPowerMask, 3'h6)
      sendCmd(8'h14, 32'h0000_0000);
      `CHK(rdValid, 1'b0)
      // port 2 masked and fixed, port 1 unmasked and removable
      sendCmd(rhpm_pkg::RHPM_CODE_WRITE, 32'h0004_0004);
      `CHK(portPowerMask, 3'h4)
      `CHK(removableDeviceFlags, 3'h4)
      readCheck(32'h0004_0004);
      // global mode ignores the mask
      pulse(1'b1, 1'b0, 3'h0, 3'h0);
      `CHK(portPowerState, 3'h6)
      pulse(1'b0, 1'b0, 3'h0, 3'h6);
      `CHK(portPowerState, 3'h6)
      pulse(1'b0, 1'b1, 3'h0, 3'h0);
      `CHK(portPowerState, 3'h0)
      // per-port mode with port 2 masked
      @(posedge clock);
      powerSwitchSelect <= 1'b1;
      pulse(1'b1, 1'b0, 3'h0, 3'h0);
      `CHK(portPowerState, 3'h2)
      pulse(1'b0, 1'b0, 3'h6, 3'h0);
      `CHK(portPowerState, 3'h6)
      pulse(1'b0, 1'b1, 3'h0, 3'h0);
      `CHK(portPowerState, 3'h4)
      pulse(1'b0, 1'b0, 3'h0, 3'h6);
      `CHK(portPowerState, 3'h0)
      pulse(1'b0, 1'b0, 3'h2, 3'h0);
      `CHK(portPowerState, 3'h0)
      // write then read on the next edge returns the new word
      @(posedge clock);
      cmdReq <= '{valid: 1'h1, code: rhpm_pkg::RHPM_CODE_WRITE,
                  wrData: 32'h0002_0002};
      @(posedge clock);
      cmdReq <= '{valid: 1'h1, code: rhpm_pkg::RHPM_CODE_READ,
                  wrData: 32'h0000_0000};
      @(posedge clock);
      cmdReq.valid <= 1'h0;
      #1;
      `CHK(rdValid, 1'h1)
      `CHK(rdData, 32'h0002_0002)
      // clearing the mask hands port 1 back to global commands
      sendCmd(rhpm_pkg::RHPM_CODE_WRITE, 32'h0000_0000);
      pulse(1'b1, 1'b0, 3'h0, 3'h0);
      `CHK(portPowerState, 3'h6)
      // mid-run reset clears the held read word and the power state
      @(posedge clock);
      rst_n <= 1'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'h1;
      #1;
      `CHK(rdData, 32'h0000_0000)
      `CHK(portPowerState, 3'h0)
      `CHK(rdValid, 1'h0)
      // per-port mode, nothing masked: globals reach both, off wins
      pulse(1'h1, 1'h0, 3'h0, 3'h0);
      `CHK(portPowerState, 3'h6)
      pulse(1'h1, 1'h1, 3'h0, 3'h0);
      `CHK(portPowerState, 3'h0)
      conclude();
   end
endmodule // rhpm_port_mask_reg_tb_top
